// File: include/irsl_map.vh
`ifndef IRSL_MAP_VH
`define IRSL_MAP_VH

// System clock rate in hertz.
`define IRSL_CLK_HZ        100000000
// Link signalling rate in baud.
`define IRSL_BAUD          9600
// Bits in one character: start, eight data, stop.
`define IRSL_CHAR_BITS     10
// Index of the stop bit within a character.
`define IRSL_STOP_IDX      4'd9
// Receiver start period divisor. A half-length start period puts every
// later bit end mid-bit, clear of the pulse edges that open each bit.
`define IRSL_RX_PHASE_DIV  2
// Listen window and inter-byte gap: 3.5 characters in bit times.
`define IRSL_WIN_BITS      35
// Zero pulse width as a fraction of the bit period.
`define IRSL_PULSE_NUM     3
`define IRSL_PULSE_DEN     16
// Listen wake period and receive inactivity timeout in seconds.
`define IRSL_WAKE_S        1
`define IRSL_RXTMO_S       10
// Pulses that make a valid wake-up.
`define IRSL_WAKE_PULSES   2'd2
// Byte that opens every packet.
`define IRSL_SYNC_BYTE     8'hc0
// Compare output modes used per transmitted bit.
`define IRSL_OUTMODE_RESET 3'h5
`define IRSL_OUTMODE_SETRST 3'h7
// Link modes.
`define IRSL_M_SLEEP       2'h0
`define IRSL_M_WIN         2'h1
`define IRSL_M_RECV        2'h2
`define IRSL_M_TX          2'h3
// Receiver states.
`define IRSL_RX_IDLE       2'h0
`define IRSL_RX_BITS       2'h1
`define IRSL_RX_GAP        2'h2
// Transmit buffer shape.
`define IRSL_FIFO_DEPTH    32
`define IRSL_FIFO_AW       5

`endif

// File: rtl/irsl_link.v
`timescale 1ns/1ps
`default_nettype none
`include "irsl_map.vh"
// Synchronous first-in first-out buffer with valid and ready on both sides.
module irsl_fifo #(
	parameter W  = 9,
	parameter D  = `IRSL_FIFO_DEPTH,
	parameter AW = `IRSL_FIFO_AW
) (
	input  wire         clk,
	input  wire         rst_n,
	input  wire         clk_en,
	input  wire [W-1:0] in_data,
	input  wire         in_valid,
	output wire         in_ready,
	output reg  [W-1:0] out_data,
	output wire         out_valid,
	input  wire         out_ready
);
	reg [W-1:0] mem_r [0:D-1];  // Storage words.
	reg [AW-1:0] wp_r;          // Write pointer.
	reg [AW-1:0] rp_r;          // Read pointer.
	reg [AW:0]   cnt_r;         // Number of stored words.
	wire         push;          // A word is written this cycle.
	wire         pop;           // A word is read this cycle.
	assign in_ready  = (cnt_r != D[AW:0]);
	assign out_valid = (cnt_r != {(AW+1){1'b0}});
	assign push      = clk_en & in_valid & in_ready;
	assign pop       = clk_en & out_valid & out_ready;
	// Show the word at the read pointer.
	always @* begin
		out_data = mem_r[rp_r];
	end
	// Write the memory; it needs no reset.
	always @(posedge clk) begin
		if (push) begin
			mem_r[wp_r] <= in_data;
		end
	end
	// Move the pointers and the fill count.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_r  <= {AW{1'b0}};
			rp_r  <= {AW{1'b0}};
			cnt_r <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wp_r <= wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= rp_r + 1'b1;
			end
			if (push && !pop) begin
				cnt_r <= cnt_r + 1'b1;
			end else if (pop && !push) begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end
endmodule
// Infrared serial link: listen cycle, receiver, and pulse transmitter.
module irsl_link #(
	parameter [31:0] BIT_CYC   = `IRSL_CLK_HZ / `IRSL_BAUD,
	parameter [31:0] WAKE_CYC  = `IRSL_CLK_HZ * `IRSL_WAKE_S,
	parameter [31:0] RXTMO_CYC = `IRSL_CLK_HZ * `IRSL_RXTMO_S
) (
	input  wire       clk,
	input  wire       rst_n,
	input  wire       clk_en,
	input  wire       ir_rx,
	output reg        ir_tx,
	output reg        ir_power,
	output reg        low_power_clocked_state,
	input  wire [7:0] tx_data,
	input  wire       tx_last,
	input  wire       tx_valid,
	output wire       tx_ready,
	output reg  [7:0] rx_data,
	output reg        rx_valid,
	output reg        rx_synced,
	output reg        packet_done_flag
);
	// Derived timing counts; pulse width rounds up to whole cycles.
	localparam [31:0] PULSE_CYC = (BIT_CYC * `IRSL_PULSE_NUM
		+ `IRSL_PULSE_DEN - 1) / `IRSL_PULSE_DEN;
	localparam [31:0] WIN_CYC = BIT_CYC * `IRSL_WIN_BITS;
	reg        rx_meta_r;   // First synchroniser stage.
	reg        rx_sync_r;   // Second synchroniser stage.
	reg        rx_prev_r;   // Delayed copy for edge capture.
	wire       cap;         // Rising edge of a received pulse.
	reg  [1:0] mode_r;      // Link mode.
	reg  [31:0] tmr_r;      // Mode timer.
	reg  [1:0] pulses_r;    // Pulses seen in the listen window.
	reg  [1:0] rx_st_r;     // Receiver state.
	reg  [31:0] rx_cyc_r;   // Bit or gap cycle counter.
	reg  [3:0] rx_bit_r;    // Bit index in the character.
	reg        rx_cap_r;    // Capture seen in this bit period.
	reg  [7:0] rx_sh_r;     // Assembling data byte.
	reg        byte_done_r; // A whole character arrived.
	wire [7:0] fifo_data;   // Next byte to send.
	wire       fifo_last;   // That byte ends the packet.
	wire       fifo_valid;  // The buffer holds a byte.
	wire       fifo_pop;    // Transmitter takes a byte.
	reg        tx_busy_r;   // A character is on the line.
	reg        tx_sync_r;   // Sync byte of this packet sent.
	reg        tx_lastb_r;  // Current character ends the packet.
	reg  [9:0] tx_sh_r;     // Outgoing character, first bit low.
	reg  [3:0] tx_bit_r;    // Bit index being sent.
	reg  [31:0] tx_cyc_r;   // Cycle within the bit.
	reg        tx_done_r;   // Last bit of the packet ended.
	wire [2:0] tx_mode;     // Compare output mode for this bit.
	assign cap = rx_sync_r & ~rx_prev_r;
	// Zero bits pulse at the bit start, ones stay dark.
	assign tx_mode  = tx_sh_r[0] ? `IRSL_OUTMODE_SETRST : `IRSL_OUTMODE_RESET;
	assign fifo_pop = (mode_r == `IRSL_M_TX) & ~tx_busy_r & tx_sync_r
		& ~tx_done_r;
	// Outgoing bytes wait here; a full buffer stalls the source.
	irsl_fifo #(
		.W  (9),
		.D  (`IRSL_FIFO_DEPTH),
		.AW (`IRSL_FIFO_AW)
	) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.clk_en    (clk_en),
		.in_data   ({tx_last, tx_data}),
		.in_valid  (tx_valid),
		.in_ready  (tx_ready),
		.out_data  ({fifo_last, fifo_data}),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop)
	);
	// Bring the pin into the clock domain before any logic reads it.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_meta_r <= 1'b0;
			rx_sync_r <= 1'b0;
			rx_prev_r <= 1'b0;
		end else if (clk_en) begin
			rx_meta_r <= ir_rx;
			rx_sync_r <= rx_meta_r;
			rx_prev_r <= rx_sync_r;
		end
	end
	// Mode sequencer: sleep, listen window, receive and transmit.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_r                  <= `IRSL_M_SLEEP;
			tmr_r                   <= 32'h0;
			pulses_r                <= 2'h0;
			ir_power                <= 1'b0;
			low_power_clocked_state <= 1'b0;
		end else if (clk_en) begin
			case (mode_r)
				`IRSL_M_SLEEP: begin
					// Transceiver off until the periodic wake.
					ir_power                <= 1'b0;
					low_power_clocked_state <= 1'b0;
					pulses_r                <= 2'h0;
					if (tmr_r == WAKE_CYC - 32'h1) begin
						tmr_r    <= 32'h0;
						mode_r   <= `IRSL_M_WIN;
						ir_power <= 1'b1;
					end else begin
						tmr_r <= tmr_r + 32'h1;
					end
				end
				`IRSL_M_WIN: begin
					if (pulses_r == `IRSL_WAKE_PULSES) begin
						// Valid wake-up: keep clocks and receive.
						mode_r                  <= `IRSL_M_RECV;
						low_power_clocked_state <= 1'b1;
						tmr_r                   <= 32'h0;
					end else if (tmr_r == WIN_CYC - 32'h1) begin
						// Too few pulses: power down again.
						mode_r   <= `IRSL_M_SLEEP;
						ir_power <= 1'b0;
						tmr_r    <= 32'h0;
					end else begin
						tmr_r <= tmr_r + 32'h1;
						if (cap) begin
							pulses_r <= pulses_r + 2'h1;
						end
					end
				end
				`IRSL_M_RECV: begin
					if (byte_done_r) begin
						// Any byte with a dark stop bit reloads the full timeout.
						tmr_r <= 32'h0;
					end else if (tmr_r == RXTMO_CYC - 32'h1) begin
						// Silence for the timeout ends receive mode.
						mode_r                  <= `IRSL_M_SLEEP;
						ir_power                <= 1'b0;
						low_power_clocked_state <= 1'b0;
						tmr_r                   <= 32'h0;
					end else if (fifo_valid && rx_st_r == `IRSL_RX_IDLE) begin
						// Send only while no character is arriving.
						mode_r <= `IRSL_M_TX;
						tmr_r  <= 32'h0;
					end else begin
						tmr_r <= tmr_r + 32'h1;
					end
				end
				`IRSL_M_TX: begin
					if (tx_done_r) begin
						// Packet out: listen for the answer.
						mode_r <= `IRSL_M_RECV;
						tmr_r  <= 32'h0;
					end
				end
				default: begin
					mode_r <= `IRSL_M_SLEEP;
				end
			endcase
		end
	end
	// Receiver: capture starts a character, bit timer decides bits.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_st_r          <= `IRSL_RX_IDLE;
			rx_cyc_r         <= 32'h0;
			rx_bit_r         <= 4'h0;
			rx_cap_r         <= 1'b0;
			rx_sh_r          <= 8'h0;
			byte_done_r      <= 1'b0;
			rx_synced        <= 1'b0;
			rx_data          <= 8'h0;
			rx_valid         <= 1'b0;
			packet_done_flag <= 1'b0;
		end else if (clk_en) begin
			byte_done_r      <= 1'b0;
			rx_valid         <= 1'b0;
			packet_done_flag <= 1'b0;
			if (mode_r != `IRSL_M_RECV) begin
				// Outside receive mode the receiver rests.
				rx_st_r   <= `IRSL_RX_IDLE;
				rx_synced <= 1'b0;
			end else begin
				case (rx_st_r)
					`IRSL_RX_IDLE, `IRSL_RX_GAP: begin
						if (cap) begin
							// Start pulse; bit ends go mid-bit.
							rx_st_r  <= `IRSL_RX_BITS;
							rx_cyc_r <= BIT_CYC / `IRSL_RX_PHASE_DIV;
							rx_bit_r <= 4'h0;
							rx_cap_r <= 1'b1;
						end else if (rx_st_r == `IRSL_RX_GAP) begin
							if (rx_cyc_r == WIN_CYC - 32'h1) begin
								// Gap over: packet done or timed out.
								packet_done_flag <= 1'b1;
								rx_synced        <= 1'b0;
								rx_st_r          <= `IRSL_RX_IDLE;
							end else begin
								rx_cyc_r <= rx_cyc_r + 32'h1;
							end
						end
					end
					`IRSL_RX_BITS: begin
						if (rx_cyc_r == BIT_CYC - 32'h1) begin
							// Bit end: a capture means zero.
							rx_cyc_r <= 32'h0;
							rx_cap_r <= 1'b0;
							if (rx_bit_r == `IRSL_STOP_IDX) begin
								// Stop must be dark, then time the gap.
								rx_st_r <= `IRSL_RX_GAP;
								if (!(rx_cap_r | cap)) begin
									byte_done_r <= 1'b1;
									if (rx_synced) begin
										// Bytes after sync go out.
										rx_data  <= rx_sh_r;
										rx_valid <= 1'b1;
									end else if (rx_sh_r == `IRSL_SYNC_BYTE) begin
										// Sync byte opens the packet.
										rx_synced <= 1'b1;
									end
								end
							end else begin
								if (rx_bit_r != 4'h0) begin
									rx_sh_r <= {~(rx_cap_r | cap), rx_sh_r[7:1]};
								end
								rx_bit_r <= rx_bit_r + 4'h1;
							end
						end else begin
							rx_cyc_r <= rx_cyc_r + 32'h1;
							if (cap) begin
								rx_cap_r <= 1'b1;
							end
						end
					end
					default: begin
						rx_st_r <= `IRSL_RX_IDLE;
					end
				endcase
			end
		end
	end
	// Transmitter: sync byte first, then buffered bytes to the last.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_busy_r  <= 1'b0;
			tx_sync_r  <= 1'b0;
			tx_lastb_r <= 1'b0;
			tx_sh_r    <= 10'h3ff;
			tx_bit_r   <= 4'h0;
			tx_cyc_r   <= 32'h0;
			tx_done_r  <= 1'b0;
			ir_tx      <= 1'b0;
		end else if (clk_en) begin
			tx_done_r <= 1'b0;
			// Pulse for a reset-mode bit during its first 3/16.
			ir_tx <= tx_busy_r & (tx_mode == `IRSL_OUTMODE_RESET)
				& (tx_cyc_r < PULSE_CYC);
			if (mode_r != `IRSL_M_TX || tx_done_r) begin
				tx_busy_r <= 1'b0;
				tx_sync_r <= 1'b0;
			end else if (!tx_busy_r) begin
				if (!tx_sync_r) begin
					// Every packet opens with the sync byte.
					tx_sh_r    <= {1'b1, `IRSL_SYNC_BYTE, 1'b0};
					tx_lastb_r <= 1'b0;
					tx_busy_r  <= 1'b1;
					tx_bit_r   <= 4'h0;
					tx_cyc_r   <= 32'h0;
				end else if (fifo_valid) begin
					// Frame: zero start, data low bit first, one stop.
					tx_sh_r    <= {1'b1, fifo_data, 1'b0};
					tx_lastb_r <= fifo_last;
					tx_busy_r  <= 1'b1;
					tx_bit_r   <= 4'h0;
					tx_cyc_r   <= 32'h0;
				end
			end else if (tx_cyc_r == BIT_CYC - 32'h1) begin
				// Bit timer paces every bit.
				tx_cyc_r <= 32'h0;
				tx_sh_r  <= {1'b1, tx_sh_r[9:1]};
				if (tx_bit_r == `IRSL_STOP_IDX) begin
					tx_busy_r <= 1'b0;
					tx_sync_r <= 1'b1;
					// Last stop bit ends transmission.
					tx_done_r <= tx_lastb_r;
				end else begin
					tx_bit_r <= tx_bit_r + 4'h1;
				end
			end else begin
				tx_cyc_r <= tx_cyc_r + 32'h1;
			end
		end
	end
endmodule
`default_nettype wire

// File: tb/irsl_handheld.sv
`timescale 1ns/1ps
`default_nettype none
// Handheld model: sends pulse-coded bytes and decodes the lit pin.
module irsl_handheld #(
	parameter int BIT_CYC = 16
) (
	input  wire logic clk,
	input  wire logic ir_tx,
	output var  logic ir_rx
);
	localparam int PULSE = (BIT_CYC * 3 + 15) / 16;
	logic [7:0] got[$];   // Bytes decoded from the device's pin.
	initial ir_rx = 1'b0; // An idle line shows no pulse.
	// Sends one character with a pulse at the head of each zero bit.
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			for (int c = 0; c < BIT_CYC; c++) begin
				@(posedge clk);
				ir_rx <= !f[i] && (c < PULSE);
			end
		end
	endtask
	// Sends a shortened wake train of all-ones characters.
	task automatic send_train(input int n);
		repeat (n) send_byte(8'hff);
	endtask
	// Decodes each character from its start pulse, one bit period a bit.
	initial begin : decode
		logic [9:0] s;
		forever begin
			if (ir_tx) begin
				s = 10'h000;
				for (int i = 0; i < 10; i++) begin
					for (int c = 0; c < BIT_CYC; c++) begin
						s[i] = s[i] | ir_tx;
						@(posedge clk);
						#1;
					end
				end
				got.push_back((s[0] && !s[9]) ? ~s[8:1] : 8'hxx);
			end else begin
				@(posedge clk);
				#1;
			end
		end
	end
endmodule
`default_nettype wire

// File: tb/irsl_link_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// Watches pulse shape and mode order at the link's ports.
module irsl_link_monitor #(
	parameter [31:0] BIT_CYC = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ir_tx,
	input wire logic ir_power,
	input wire logic low_power_clocked_state,
	input wire logic rx_valid,
	input wire logic rx_synced,
	input wire logic packet_done_flag
);
	// Pulse width rounded up, and the shortest dark run between pulses.
	localparam logic [7:0] PULSE = 8'((BIT_CYC * 3 + 15) / 16);
	localparam logic [7:0] GAP   = 8'(BIT_CYC) - PULSE;
	logic [7:0] hi_r; // Cycles lit so far.
	logic [7:0] lo_r; // Cycles dark so far, saturating.
	// Measures lit and dark runs of the drive pin.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hi_r <= 8'h00;
			lo_r <= 8'hff;
		end else if (ir_tx) begin
			hi_r <= hi_r + 8'h01;
			lo_r <= 8'h00;
		end else begin
			hi_r <= 8'h00;
			lo_r <= (lo_r == 8'hff) ? lo_r : lo_r + 8'h01;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// After a done pulse the flag drops and the packet is unsynced.
	sequence s_done_clear;
		!packet_done_flag && !rx_synced;
	endsequence
	property p_pulse_len; $fell(ir_tx) |-> hi_r == PULSE; endproperty
	a_pulse_len: assert property (p_pulse_len)
		else $error("lit pulse has wrong width");
	property p_pulse_gap; $rose(ir_tx) |-> lo_r >= GAP; endproperty
	a_pulse_gap: assert property (p_pulse_gap)
		else $error("pulses closer than one bit");
	property p_dark_off; !ir_power |-> !ir_tx; endproperty
	a_dark_off: assert property (p_dark_off)
		else $error("pin lit while powered down");
	property p_tx_mode; ir_tx |-> low_power_clocked_state; endproperty
	a_tx_mode: assert property (p_tx_mode)
		else $error("pin lit outside active mode");
	property p_rx_sync; rx_valid |-> rx_synced ##1 !rx_valid; endproperty
	a_rx_sync: assert property (p_rx_sync)
		else $error("byte out while unsynced or too long");
	property p_done; packet_done_flag |=> s_done_clear; endproperty
	a_done: assert property (p_done)
		else $error("done pulse not single or sync kept");
	property p_wake;
		$rose(low_power_clocked_state) |-> $past(ir_power);
	endproperty
	a_wake: assert property (p_wake)
		else $error("woke without a listen window");
	property p_on; low_power_clocked_state |-> ir_power; endproperty
	a_on: assert property (p_on)
		else $error("active mode with transceiver off");
	property p_off; $fell(low_power_clocked_state) |-> !ir_power; endproperty
	a_off: assert property (p_off)
		else $error("left active mode with power on");
endmodule
bind irsl_link irsl_link_monitor #(.BIT_CYC(BIT_CYC)) mon (
	.clk(clk), .rst_n(rst_n), .ir_tx(ir_tx), .ir_power(ir_power),
	.low_power_clocked_state(low_power_clocked_state),
	.rx_valid(rx_valid), .rx_synced(rx_synced),
	.packet_done_flag(packet_done_flag)
);
`default_nettype wire

// File: tb/irsl_link_tb.sv
`timescale 1ns/1ps
`default_nettype none
// Drives the link against the handheld model and judges its ports.
module irsl_link_tb;
	localparam int BIT  = 16;       // Shortened bit period.
	localparam int WAKE = 2000;     // Shortened wake period.
	localparam int TMO  = 5000;     // Shortened receive timeout.
	localparam int WIN  = 35 * BIT; // Listen window and byte gap.
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       clk_en = 1'b1; // Freezes the whole block while low.
	logic       ir_rx, ir_tx, ir_power, lp_on, tx_ready;
	logic [7:0] tx_data = 8'h00;
	logic       tx_last = 1'b0;
	logic       tx_valid = 1'b0;
	logic [7:0] rx_data;
	logic       rx_valid, rx_synced, done;
	logic       done_seen = 1'b0; // Latches any done pulse.
	logic [7:0] rxq[$];           // Bytes handed out by the receiver.
	int         fails = 0;
	int         num_checks = 0;
	int         t;
	always #5 clk = ~clk;
	irsl_link #(.BIT_CYC(BIT), .WAKE_CYC(WAKE), .RXTMO_CYC(TMO)) dut (
		.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .ir_rx(ir_rx),
		.ir_tx(ir_tx), .ir_power(ir_power),
		.low_power_clocked_state(lp_on), .tx_data(tx_data),
		.tx_last(tx_last), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.rx_data(rx_data), .rx_valid(rx_valid), .rx_synced(rx_synced),
		.packet_done_flag(done));
	irsl_handheld #(.BIT_CYC(BIT)) hh (
		.clk(clk), .ir_tx(ir_tx), .ir_rx(ir_rx));
	// Collects receiver output and done pulses as presented.
	always @(posedge clk) begin
		if (rx_valid) rxq.push_back(rx_data);
		if (done) done_seen <= 1'b1;
	end
	task automatic check(input string n, input logic [7:0] e, g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	// Waits a bounded number of cycles; t holds the cycles spent.
	task automatic wait_on(ref logic s, input logic v, input int n);
		for (t = 0; t < n && s !== v; t++) @(negedge clk);
		if (s !== v) begin
			fails++;
			$display("[ERR] wait exp %b got %b", v, s);
			give_verdict();
		end
	endtask
	task automatic t_fill;
		// A stray word offered while frozen must not enter the buffer,
		// or the ready count and every sent byte below would shift.
		@(posedge clk);
		clk_en <= 1'b0;
		tx_valid <= 1'b1;
		tx_data <= 8'hee;
		repeat (3) @(posedge clk);
		clk_en <= 1'b1;
		tx_valid <= 1'b0;
		for (int i = 0; i < 33; i++) begin
			@(posedge clk);
			tx_valid <= 1'b1;
			tx_data <= 8'h10 + 8'(i);
			tx_last <= (i == 31);
			@(negedge clk);
			check("ready", (i < 32), tx_ready);
		end
		@(posedge clk);
		tx_valid <= 1'b0;
		$display("t_fill finished");
	endtask
	task automatic t_listen;
		wait_on(ir_power, 1'b1, WAKE + 10);
		wait_on(ir_power, 1'b0, WIN + 10);
		check("window", 1, t >= WIN - 2 && t <= WIN + 2);
		check("lp_on", 0, lp_on);
		wait_on(ir_power, 1'b1, WAKE + 10);
		check("sleep", 1, t >= WAKE - 2 && t <= WAKE + 2);
		hh.send_train(3);
		check("woken", 1, lp_on & ir_power);
		$display("t_listen finished");
	endtask
	task automatic t_tx;
		for (t = 0; t < 9000 && hh.got.size() < 33; t++) @(negedge clk);
		check("tx count", 8'd33, 8'(hh.got.size()));
		if (hh.got.size() < 33) give_verdict();
		for (int i = 0; i < 33; i++)
			check("tx byte", i ? 8'h0f + 8'(i) : 8'hc0, hh.got[i]);
		check("back rx", 1, lp_on & ir_power & tx_ready);
		$display("t_tx finished");
	endtask
	task automatic t_rx;
		logic [7:0] pkt[5] = '{8'h55, 8'hc0, 8'h12, 8'hc0, 8'ha5};
		logic [7:0] exp[3] = '{8'h12, 8'hc0, 8'ha5};
		rxq.delete();
		@(posedge clk);
		done_seen <= 1'b0;
		foreach (pkt[i]) hh.send_byte(pkt[i]);
		check("synced", 1, rx_synced);
		wait_on(done_seen, 1'b1, WIN + 40);
		check("gap", 1, t >= WIN - 10);
		check("unsynced", 0, rx_synced);
		check("rx count", 8'd3, 8'(rxq.size()));
		foreach (exp[i]) check("rx byte", exp[i], rxq[i]);
		$display("t_rx finished");
	endtask
	task automatic t_tmo;
		repeat (4000) @(negedge clk);
		hh.send_byte(8'h00);
		repeat (1000) @(negedge clk);
		check("kept", 1, lp_on);
		wait_on(lp_on, 1'b0, TMO);
		check("tmo", 1, t >= TMO - 1020 && t <= TMO - 980);
		check("off", 0, ir_power);
		$display("t_tmo finished");
	endtask
	task give_verdict;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		check("reset", 8'h01, {1'b0, ir_tx, ir_power, lp_on, rx_valid,
			rx_synced, done, tx_ready});
		t_fill();
		t_listen();
		t_tx();
		t_rx();
		t_tmo();
		give_verdict();
	end
endmodule
`default_nettype wire
